/* File: hw/rstc_consts.vh */
`ifndef RSTC_CONSTS_VH
`define RSTC_CONSTS_VH

// ***************************************************
// register offsets (byte addresses)
// ***************************************************
`define OFS_CTRL 8'h00
`define OFS_WAIT_SEL 8'h04
`define OFS_STATUS 8'h08
`define OFS_CAUSE 8'h0C

// ***************************************************
// field positions
// ***************************************************
`define CTRL_HALT_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_XTAL_BIT 2
`define CTRL_PORT_MODE_BIT 3
`define CAUSE_PIN_BIT 0
`define CAUSE_POC_BIT 1
`define CAUSE_LVD_BIT 2
`define CAUSE_WDT_BIT 3

// ***************************************************
// reset values
// ***************************************************
`define CTRL_RESET 4'h0
`define WAIT_SEL_RESET 3'h4

// ***************************************************
// timing
// ***************************************************
`define CLK_MHZ 10
`define STOP_FIXED_NS 34000
`define CLK_PERIOD_NS 100
`define STOP_FIXED_CYC (`STOP_FIXED_NS / `CLK_PERIOD_NS)
`define STAB_BASE_CYC 16

`endif

/* File: hw/wait_counter.v */
`timescale 1ns/1ps
`include "rstc_consts.vh"

// ***************************************************
// loadable down counter, done pulse at zero
// ***************************************************
module wait_counter #(
    parameter WIDTH = 20
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // control
    input wire load_i,
    input wire [WIDTH-1:0] count_i,
    input wire run_i,
    // status
    output reg busy_o,
    output reg done_o
);
    reg [WIDTH-1:0] cnt;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt <= {WIDTH{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                cnt <= count_i;
                busy_o <= 1'b1;
            end else if (busy_o && run_i) begin
                if (cnt <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt <= cnt - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: hw/reset_standby_control.v */
`timescale 1ns/1ps
`include "rstc_consts.vh"

// Notes on behaviour
// - power-up wait from config byte setting
// - pending unmasked interrupt ends halt at once, stop after the release wait
// - stop release waits 34 us typical
// - crystal clock adds selected stabilisation wait
// - oscillators stopped while any reset active
// - input-port pin low resets before reread
// - that pin reset holds until high
// - detector reset spares detector logic
// - watchdog reset also resets watchdog
// - stop wait counts after oscillation starts
module reset_standby_control #(
    parameter NUM_IRQ = 8,
    parameter WAIT_W = 20
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // reset sources
    input wire reset_pin_n_i,
    input wire power_on_clear_circuit_i,
    input wire low_voltage_detector_i,
    input wire wdt_overflow_i,
    // configuration byte
    input wire [2:0] cfg_stab_sel_i,
    input wire cfg_load_i,
    // interrupt sources
    input wire [NUM_IRQ-1:0] irq_flag_i,
    input wire [NUM_IRQ-1:0] irq_mask_i,
    // oscillator handshake
    input wire osc_started_i,
    // outputs
    output reg osc_enable_o,
    output reg cpu_reset_o,
    output reg cpu_halted_o,
    output reg lvd_reset_o,
    output reg wdt_reset_o,
    output reg periph_reset_o
);
    // ***************************************************
    // states
    // ***************************************************
    localparam ST_RESET = 3'd0;
    localparam ST_OSC = 3'd1;
    localparam ST_STAB = 3'd2;
    localparam ST_RUN = 3'd3;
    localparam ST_HALT = 3'd4;
    localparam ST_STOP = 3'd5;
    localparam ST_FIXED = 3'd6;
    localparam [WAIT_W-1:0] FIXED_CYC = `STOP_FIXED_CYC;
    localparam [WAIT_W-1:0] BASE_CYC = `STAB_BASE_CYC;

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    reg [1:0] pin_s;
    reg [1:0] poc_s;
    reg [1:0] lvd_s;
    reg [1:0] wdt_s;
    reg [1:0] osc_s;
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_s <= 2'h3;
            poc_s <= 2'h0;
            lvd_s <= 2'h0;
            wdt_s <= 2'h0;
            osc_s <= 2'h0;
        end else begin
            pin_s <= {pin_s[0], reset_pin_n_i};
            poc_s <= {poc_s[0], power_on_clear_circuit_i};
            lvd_s <= {lvd_s[0], low_voltage_detector_i};
            wdt_s <= {wdt_s[0], wdt_overflow_i};
            osc_s <= {osc_s[0], osc_started_i};
        end
    end
    wire pin_low = ~pin_s[1];
    wire power_on_clear_circuit = poc_s[1];
    wire lvd = lvd_s[1];
    wire wdt = wdt_s[1];
    wire osc_ok = osc_s[1];

    // ***************************************************
    // registers
    // ***************************************************
    reg [3:0] ctrl;
    reg [2:0] wait_sel;
    reg [2:0] cfg_sel;
    reg [3:0] cause;
    reg [2:0] state;
    reg cfg_pending;
    wire port_mode = ctrl[`CTRL_PORT_MODE_BIT];

    reg pin_held;
    wire pin_rst = pin_low & (~port_mode | cfg_pending | pin_held);

    // pin reset kept until pin high
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            pin_held <= 1'b0;
        end else begin
            pin_held <= pin_rst;
        end
    end
    wire any_rst = pin_rst | power_on_clear_circuit | lvd | wdt;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_sel <= `WAIT_SEL_RESET;
            cfg_pending <= 1'b1;
        end else begin
            if (cfg_load_i) begin
                cfg_sel <= cfg_stab_sel_i;
                cfg_pending <= 1'b0;
            end else if (power_on_clear_circuit | lvd | wdt) begin
                cfg_pending <= 1'b1;
            end
        end
    end

    // ***************************************************
    // axi4-lite slave
    // ***************************************************
    reg aw_hold;
    reg w_hold;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire aw_have = aw_hold | s_axi_awvalid;
    wire w_have = w_hold | s_axi_wvalid;
    wire [7:0] wa = aw_hold ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_hold ? w_data : s_axi_wdata;
    wire [3:0] ws = w_hold ? w_strb : s_axi_wstrb;
    wire do_wr = aw_have & w_have & ~s_axi_bvalid;
    wire wr_ctrl = do_wr & (wa == `OFS_CTRL) & ws[0];
    wire wr_sel = do_wr & (wa == `OFS_WAIT_SEL) & ws[0];
    wire wr_cause = do_wr & (wa == `OFS_CAUSE) & ws[0];
    wire wr_ok = (wa == `OFS_CTRL) | (wa == `OFS_WAIT_SEL) | (wa == `OFS_CAUSE);
    wire standby_req = ctrl[`CTRL_HALT_BIT] | ctrl[`CTRL_STOP_BIT];

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl <= `CTRL_RESET;
            wait_sel <= `WAIT_SEL_RESET;
        end else begin
            if (s_axi_awvalid & s_axi_awready & ~do_wr) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~do_wr) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // standby request bits drop once standby is entered
            if (wr_ctrl) begin
                ctrl <= wd[3:0];
            end else if (state == ST_HALT || state == ST_STOP) begin
                ctrl[`CTRL_HALT_BIT] <= 1'b0;
                ctrl[`CTRL_STOP_BIT] <= 1'b0;
            end
            if (wr_sel) begin
                wait_sel <= wd[2:0];
            end
        end
    end

    // cause flags: set wins over write-one-to-clear
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cause <= 4'h0;
        end else begin
            cause <= (cause & ~(wr_cause ? wd[3:0] : 4'h0)) | {wdt, lvd, power_on_clear_circuit, pin_rst};
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
                `OFS_CTRL: s_axi_rdata <= {28'h0, ctrl};
                `OFS_WAIT_SEL: s_axi_rdata <= {29'h0, wait_sel};
                `OFS_STATUS: s_axi_rdata <= {25'h0, cfg_sel, state, cfg_pending};
                `OFS_CAUSE: s_axi_rdata <= {28'h0, cause};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ***************************************************
    // sequencer
    // ***************************************************
    // pending unmasked interrupt
    wire wake = |(irq_flag_i & ~irq_mask_i);
    reg load;
    reg [WAIT_W-1:0] load_val;
    wire cnt_busy;
    wire cnt_done;
    reg [2:0] next_state;

    wire [WAIT_W-1:0] cfg_cyc = BASE_CYC << cfg_sel;
    wire [WAIT_W-1:0] sel_cyc = BASE_CYC << wait_sel;

    always @* begin
        next_state = state;
        load = 1'b0;
        load_val = {WAIT_W{1'b0}};
        case (state)
            ST_RESET: begin
                if (!any_rst)
                    next_state = ST_OSC;
            end
            ST_OSC: begin
                if (osc_ok) begin
                    load = 1'b1;
                    next_state = ST_STAB;
                    if (cpu_reset_o) begin
                        load_val = cfg_cyc;
                    end else if (ctrl[`CTRL_XTAL_BIT]) begin
                        load_val = sel_cyc;
                    end else begin
                        load_val = FIXED_CYC;
                        next_state = ST_FIXED;
                    end
                end
            end
            ST_STAB: begin
                if (cnt_done) begin
                    if (cpu_reset_o) begin
                        next_state = ST_RUN;
                    end else begin
                        load = 1'b1;
                        load_val = FIXED_CYC;
                        next_state = ST_FIXED;
                    end
                end
            end
            ST_FIXED: begin
                if (cnt_done)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (ctrl[`CTRL_STOP_BIT] && !wake)
                    next_state = ST_STOP;
                else if (ctrl[`CTRL_HALT_BIT] && !wake)
                    next_state = ST_HALT;
            end
            ST_HALT: begin
                if (wake)
                    next_state = ST_RUN;
            end
            ST_STOP: begin
                // stale oscillator flag must clear first
                if (wake && !osc_ok)
                    next_state = ST_OSC;
            end
            default: next_state = ST_RESET;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= ST_RESET;
            cpu_reset_o <= 1'b1;
        end else if (any_rst) begin
            state <= ST_RESET;
            cpu_reset_o <= 1'b1;
        end else begin
            state <= next_state;
            if (state == ST_STAB && cnt_done)
                cpu_reset_o <= 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            osc_enable_o <= 1'b0;
            cpu_halted_o <= 1'b1;
            lvd_reset_o <= 1'b1;
            wdt_reset_o <= 1'b1;
            periph_reset_o <= 1'b1;
        end else begin
            osc_enable_o <= ~any_rst & (next_state != ST_STOP) & (state != ST_STOP);
            cpu_halted_o <= any_rst | (next_state != ST_RUN);
            lvd_reset_o <= pin_rst | power_on_clear_circuit | wdt;
            wdt_reset_o <= any_rst;
            periph_reset_o <= any_rst;
        end
    end

    wait_counter #(
        .WIDTH(WAIT_W)
    ) u_wait (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i | any_rst),
        .load_i(load),
        .count_i(load_val),
        .run_i(osc_ok),
        .busy_o(cnt_busy),
        .done_o(cnt_done)
    );
endmodule

/* File: dv/osc_partner.sv */
`timescale 1ns/1ps
// ***************************************************
// oscillator and reset pin model
// ***************************************************
module osc_partner (
    // clock
    input wire core_clk_i,
    // requests
    input wire osc_enable_i,
    input wire slow_i,
    input wire pin_req_i,
    // far side
    output logic osc_started_o = 1'b0,
    output logic reset_pin_n_o = 1'b1
);
    int run = 0;
    int low = 0;
    always @(posedge core_clk_i) begin
        run <= osc_enable_i ? run + 1 : 0;
        osc_started_o <= osc_enable_i && run >= (slow_i ? 40 : 3);
        low <= (pin_req_i || (low > 0 && low < 20)) ? low + 1 : 0;
        reset_pin_n_o <= !(pin_req_i || (low > 0 && low < 20));
    end
endmodule

/* File: dv/reset_standby_control_chk.sv */
`timescale 1ns/1ps
// ***************************************************
// port checker
// ***************************************************
module reset_standby_control_chk #(
    parameter NUM_IRQ = 8
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // inputs
    input wire reset_pin_n_i,
    input wire power_on_clear_circuit_i,
    input wire low_voltage_detector_i,
    input wire wdt_overflow_i,
    input wire [2:0] cfg_stab_sel_i,
    input wire cfg_load_i,
    input wire [NUM_IRQ-1:0] irq_flag_i,
    input wire [NUM_IRQ-1:0] irq_mask_i,
    input wire osc_started_i,
    input wire s_axi_bready,
    input wire s_axi_rready,
    // outputs
    input wire s_axi_bvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire osc_enable_o,
    input wire cpu_reset_o,
    input wire cpu_halted_o,
    input wire lvd_reset_o,
    input wire wdt_reset_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire pend = |(irq_flag_i & ~irq_mask_i);
    reg [2:0] cfg_q;
    reg was_stop;
    reg [15:0] cnt;
    // cycles with a running clock while the cpu is halted
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cfg_q <= 3'h4;
            was_stop <= 1'b0;
            cnt <= 16'h0;
        end else begin
            if (cfg_load_i) cfg_q <= cfg_stab_sel_i;
            was_stop <= cpu_halted_o && !cpu_reset_o && (was_stop || !osc_enable_o);
            cnt <= cpu_halted_o ? cnt + {15'h0, osc_started_i && osc_enable_o} : 16'h0;
        end
    end
    a_osc_stopped: assert property (
        (power_on_clear_circuit_i || low_voltage_detector_i || wdt_overflow_i)[*5]
        |-> !osc_enable_o) else $error("osc on in reset");
    a_lvd_spared: assert property (
        (low_voltage_detector_i && !power_on_clear_circuit_i && !wdt_overflow_i
        && reset_pin_n_i)[*5] |-> wdt_reset_o && !lvd_reset_o) else $error("lvd self reset");
    a_wdt_self: assert property (
        wdt_overflow_i[*5] |-> wdt_reset_o && lvd_reset_o) else $error("wdt not reset");
    a_irq_blocks_standby: assert property (
        pend && !cpu_halted_o ##1 pend && !cpu_halted_o |=> !cpu_halted_o || cpu_reset_o)
        else $error("standby with irq pending");
    a_stop_wait: assert property (
        $fell(cpu_halted_o) && was_stop |-> cnt >= 16'd341) else $error("stop wait short");
    a_cfg_wait: assert property (
        $fell(cpu_reset_o) |-> cnt >= (16'd16 << cfg_q)) else $error("reset wait short");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
endmodule

/* File: dv/reset_standby_control_tb.sv */
`timescale 1ns/1ps
`include "rstc_consts.vh"
module reset_standby_control_tb;
    logic core_clk_i = 1'b0, rst_i = 1'b1, cfg_load_i = 1'b0, slow = 1'b0, pin_req = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [7:0] irq_flag_i = 8'h00, irq_mask_i = 8'hFF;
    logic [31:0] s_axi_wdata = 32'h0, seed = 32'hB614CB97;
    logic [2:0] src = 3'h0, cfg_stab_sel_i = 3'h0, sel;
    logic [34:0] e;
    logic [34:0] q[$];
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire reset_pin_n_i, osc_started_i, osc_enable_o, cpu_reset_o, cpu_halted_o;
    wire lvd_reset_o, wdt_reset_o;
    int err_count = 0, tests_run = 0, cycles = 0, n, i;
    reset_standby_control i_dut (
        .core_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_n_i,
        .power_on_clear_circuit_i(src[0]), .low_voltage_detector_i(src[1]),
        .wdt_overflow_i(src[2]), .cfg_stab_sel_i, .cfg_load_i, .irq_flag_i, .irq_mask_i,
        .osc_started_i, .osc_enable_o, .cpu_reset_o, .cpu_halted_o, .lvd_reset_o,
        .wdt_reset_o, .periph_reset_o()
    );
    osc_partner i_osc (
        .core_clk_i, .osc_enable_i(osc_enable_o), .slow_i(slow), .pin_req_i(pin_req),
        .osc_started_o(osc_started_i), .reset_pin_n_o(reset_pin_n_i)
    );
    initial forever #50 core_clk_i = ~core_clk_i;
    function logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic sig(input int k);
        sig = k == 0 ? cpu_reset_o : (k == 1 ? cpu_halted_o : osc_enable_o);
    endfunction
    task wrap_up;
        begin
            $display("checks %0d errors %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input logic [33:0] got, input logic [33:0] exp);
        begin
            tests_run++;
            if (got !== exp) begin
                err_count++;
                $display("wrong value at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    task till(input int k, input logic v, output int c);
        begin
            c = 0;
            do begin
                @(negedge core_clk_i);
                c++;
            end while (sig(k) !== v);
            @(posedge core_clk_i);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic v, ha, hw, hr, dn;
        begin
            q.push_back({w, r, d});
            dn = 1'b0;
            if (w) begin
                s_axi_awaddr <= a;
                s_axi_wdata <= d;
                s_axi_awvalid <= 1'b1;
                s_axi_wvalid <= 1'b1;
            end else begin
                s_axi_araddr <= a;
                s_axi_arvalid <= 1'b1;
            end
            while (!dn) begin
                @(negedge core_clk_i);
                ha = s_axi_awready && s_axi_awvalid;
                hw = s_axi_wready && s_axi_wvalid;
                hr = s_axi_arready && s_axi_arvalid;
                v = w ? s_axi_bvalid : s_axi_rvalid;
                dn = v && (s_axi_bready || s_axi_rready);
                @(posedge core_clk_i);
                if (ha) s_axi_awvalid <= 1'b0;
                if (hw) s_axi_wvalid <= 1'b0;
                if (hr) s_axi_arvalid <= 1'b0;
                s_axi_bready <= w && v && !dn;
                s_axi_rready <= !w && v && !dn;
            end
        end
    endtask
    always @(negedge core_clk_i) begin
        if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready) begin
            e = q.pop_front();
            if (e[34]) chk({s_axi_bresp, 32'h0}, {e[33:32], 32'h0});
            else chk({s_axi_rresp, s_axi_rdata}, e[33:0]);
        end
    end
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 50000) begin
            err_count++;
            wrap_up;
        end
    end
    initial begin
        cyc(2);
        rst_i <= 1'b0;
        till(0, 1'b0, n);
        chk(n >= 256, 1'b1);
        xfer(0, `OFS_CTRL, 32'h0, 2'h0);
        xfer(0, `OFS_WAIT_SEL, 32'h4, 2'h0);
        xfer(0, 8'h10, 32'h0, 2'h2);
        xfer(1, `OFS_CAUSE, 32'hF, 2'h0);
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            sel = seed[2:0];
            cfg_stab_sel_i <= sel;
            cfg_load_i <= 1'b1;
            cyc(1);
            cfg_load_i <= 1'b0;
            src <= 3'h1 << i;
            cyc(8);
            @(negedge core_clk_i);
            chk(osc_enable_o, 1'b0);
            chk(lvd_reset_o, i != 1);
            chk(wdt_reset_o, 1'b1);
            @(posedge core_clk_i);
            src <= 3'h0;
            till(2, 1'b1, n);
            till(0, 1'b0, n);
            chk(n >= (16 << sel), 1'b1);
            xfer(0, `OFS_CAUSE, 32'h2 << i, 2'h0);
            xfer(1, `OFS_CAUSE, 32'hF, 2'h0);
        end
        xfer(1, `OFS_CTRL, 32'h8, 2'h0);
        pin_req <= 1'b1;
        cyc(40);
        @(negedge core_clk_i);
        chk(cpu_reset_o, 1'b1);
        @(posedge core_clk_i);
        pin_req <= 1'b0;
        till(0, 1'b0, n);
        cfg_load_i <= 1'b1;
        cyc(1);
        cfg_load_i <= 1'b0;
        xfer(1, `OFS_CTRL, 32'h8, 2'h0);
        pin_req <= 1'b1;
        cyc(30);
        @(negedge core_clk_i);
        chk(cpu_reset_o, 1'b0);
        @(posedge core_clk_i);
        pin_req <= 1'b0;
        seed = lfsr(seed);
        irq_flag_i <= 8'h1 << seed[2:0];
        xfer(1, `OFS_CTRL, 32'h9, 2'h0);
        @(negedge core_clk_i);
        chk(cpu_halted_o, 1'b1);
        @(posedge core_clk_i);
        irq_mask_i <= 8'h00;
        till(1, 1'b0, n);
        chk(n <= 4, 1'b1);
        for (i = 1; i < 3; i++) begin
            xfer(1, `OFS_CTRL, {30'h2, i[1:0]}, 2'h0);
            @(negedge core_clk_i);
            chk(cpu_halted_o, 1'b0);
            @(posedge core_clk_i);
        end
        for (i = 0; i < 2; i++) begin
            irq_flag_i <= 8'h00;
            slow <= i[0];
            xfer(1, `OFS_WAIT_SEL, {29'h0, sel}, 2'h0);
            xfer(1, `OFS_CTRL, i ? 32'h6 : 32'h2, 2'h0);
            till(2, 1'b0, n);
            irq_flag_i <= 8'hFF;
            till(2, 1'b1, n);
            till(1, 1'b0, n);
            chk(n >= 340 + (i ? 40 + (16 << sel) : 3), 1'b1);
        end
        wrap_up;
    end
endmodule
bind reset_standby_control reset_standby_control_chk #(.NUM_IRQ(NUM_IRQ)) i_chk (
    .core_clk_i, .rst_i, .reset_pin_n_i, .power_on_clear_circuit_i, .low_voltage_detector_i,
    .wdt_overflow_i, .cfg_stab_sel_i, .cfg_load_i, .irq_flag_i, .irq_mask_i, .osc_started_i,
    .s_axi_bready, .s_axi_rready, .s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid, .s_axi_rdata,
    .osc_enable_o, .cpu_reset_o, .cpu_halted_o, .lvd_reset_o, .wdt_reset_o
);
